/* logic/smsc_ctrl.sv */
// Standby wait and module stop controller with AHB-Lite register access.
//
// Overview of operation
// - Main wait code is five bits; codes 0 to 4 wait 2,4,8,16,32 cycles.
// - Main wait codes 5 to 15 wait 64 up to 524288 cycles.
// - Subclock wait code is five bits at bit 0, 2 to 524288 cycles.
// - Standby bit 14 enables output ports, bit 15 selects software standby.
// - Stop register A bit 31 stops all module clocks when mode entered.
// - Register A bits 4,5,9,10,11 stop timer and pulse generator units.
// - Register A bits 12,13 stop pulse units, 14,15 compare timers.
// - Register A bits 17,19,23,28,29 stop converters and DMA controllers.
// - Register A bits 8,22 reserved; bits 24,27 generic stop bits.
// - Register B bits 0,1,2 CAN, 4 serial variant, 8 temperature sensor.
// - Register B bits 15 to 21 and 23 stop DMA, SPI, USB, I2C, CRC.
// - Register B bits 24 to 31 stop serial interfaces 7 down to 0.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module smsc_ctrl (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        MAIN_OSC_IN,
  input  wire logic        SUB_OSC_IN,
  input  wire logic        STANDBY_ENTRY,
  output logic             MAIN_OSC_ENABLE,
  output logic             SUB_OSC_ENABLE,
  output logic             MAIN_OSC_STABLE,
  output logic             SUB_OSC_STABLE,
  output logic             OUTPUT_PORT_ENABLE,
  output logic             SOFTWARE_STANDBY_SELECT,
  output logic             ALL_MODULE_STOP,
  output logic      [31:0] MODULE_STOP_A,
  output logic      [31:0] MODULE_STOP_B
);

  localparam logic [31:0] STOP_A_MASK = smsc_pkg::SMSC_A_TIMER
                                      | smsc_pkg::SMSC_A_TPU_CMT
                                      | smsc_pkg::SMSC_A_CONV
                                      | smsc_pkg::SMSC_A_GENERIC
                                      | smsc_pkg::SMSC_A_ALL_MODULE_CLOCK_STOP_ENABLE;
  localparam logic [31:0] STOP_B_MASK = smsc_pkg::SMSC_B_CAN_TEMP
                                      | smsc_pkg::SMSC_B_COMM
                                      | smsc_pkg::SMSC_B_SCI;

  // Registers.
  logic [15:0] standby_control_ff;
  logic [7:0]  main_osc_wait_control_ff;
  logic [7:0]  sub_osc_wait_control_ff;
  logic [31:0] module_stop_control_a_ff;
  logic [31:0] module_stop_control_b_ff;
  logic [1:0]  osc_control_ff;
  logic [15:0] nxt_standby_control;
  logic [7:0]  nxt_main_osc_wait_control;
  logic [7:0]  nxt_sub_osc_wait_control;
  logic [31:0] nxt_module_stop_control_a;
  logic [31:0] nxt_module_stop_control_b;
  logic [1:0]  nxt_osc_control;

  // Bus state.
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] rdata_ff;
  logic        bus_take;
  logic        wr_take;
  logic [31:0] rd_word;

  // Write decode.
  logic        sel_stby;
  logic        sel_main_wt;
  logic        sel_sub_wt;
  logic        sel_stop_a;
  logic        sel_stop_b;
  logic        sel_osc_ctl;

  // Oscillator pin synchronisers.
  logic [1:0]  osc_s1_ff;
  logic [1:0]  osc_s2_ff;
  logic [1:0]  osc_d_ff;
  logic [1:0]  osc_tick;

  // Output registers.
  logic        all_stop_ff;
  logic [31:0] stop_a_out_ff;
  logic [31:0] stop_b_out_ff;
  logic        all_stop_now;
  logic [31:0] wr_stop_a;
  logic [31:0] wr_stop_b;
  logic [31:0] osc_status;

  smsc_wait_if main_if ();
  smsc_wait_if sub_if ();

  // The bus never stalls and never signals an error.
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_ff;

  assign bus_take = HSEL & HREADY & HTRANS[1];
  assign wr_take  = bus_take & HWRITE & (HSIZE == smsc_pkg::SMSC_HSIZE_WORD);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= wr_take;
      wr_addr_ff <= HADDR[7:0];
    end
  end

  always_comb begin
    sel_stby    = 1'b0;
    sel_main_wt = 1'b0;
    sel_sub_wt  = 1'b0;
    sel_stop_a  = 1'b0;
    sel_stop_b  = 1'b0;
    sel_osc_ctl = 1'b0;
    if (!wr_pend_ff) begin
      sel_stby = 1'b0;
    end else if (wr_addr_ff == smsc_pkg::SMSC_OFS_STBY) begin
      sel_stby = 1'b1;
    end else if (wr_addr_ff == smsc_pkg::SMSC_OFS_MAIN_WT) begin
      sel_main_wt = 1'b1;
    end else if (wr_addr_ff == smsc_pkg::SMSC_OFS_SUB_WT) begin
      sel_sub_wt = 1'b1;
    end else if (wr_addr_ff == smsc_pkg::SMSC_OFS_STOP_A) begin
      sel_stop_a = 1'b1;
    end else if (wr_addr_ff == smsc_pkg::SMSC_OFS_STOP_B) begin
      sel_stop_b = 1'b1;
    end else if (wr_addr_ff == smsc_pkg::SMSC_OFS_OSC_CTL) begin
      sel_osc_ctl = 1'b1;
    end
  end

  // Reserved bits are masked on write so they always read back as zero.
  assign wr_stop_a = HWDATA & STOP_A_MASK;
  assign wr_stop_b = HWDATA & STOP_B_MASK;

  assign nxt_standby_control       = sel_stby ? (HWDATA[15:0] & smsc_pkg::SMSC_STBY_MASK)
                                              : standby_control_ff;
  assign nxt_main_osc_wait_control = sel_main_wt ? (HWDATA[7:0] & smsc_pkg::SMSC_WAIT_MASK)
                                                 : main_osc_wait_control_ff;
  assign nxt_sub_osc_wait_control  = sel_sub_wt ? (HWDATA[7:0] & smsc_pkg::SMSC_WAIT_MASK)
                                                : sub_osc_wait_control_ff;
  assign nxt_module_stop_control_a = sel_stop_a ? wr_stop_a : module_stop_control_a_ff;
  assign nxt_module_stop_control_b = sel_stop_b ? wr_stop_b : module_stop_control_b_ff;
  assign nxt_osc_control           = sel_osc_ctl ? HWDATA[1:0] : osc_control_ff;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      standby_control_ff       <= smsc_pkg::SMSC_STBY_RST;
      main_osc_wait_control_ff <= smsc_pkg::SMSC_WAIT_RST;
      sub_osc_wait_control_ff  <= smsc_pkg::SMSC_WAIT_RST;
      module_stop_control_a_ff <= smsc_pkg::SMSC_STOP_A_RST;
      module_stop_control_b_ff <= smsc_pkg::SMSC_STOP_B_RST;
      osc_control_ff           <= smsc_pkg::SMSC_OSC_CTL_RST;
    end else begin
      standby_control_ff       <= nxt_standby_control;
      main_osc_wait_control_ff <= nxt_main_osc_wait_control;
      sub_osc_wait_control_ff  <= nxt_sub_osc_wait_control;
      module_stop_control_a_ff <= nxt_module_stop_control_a;
      module_stop_control_b_ff <= nxt_module_stop_control_b;
      osc_control_ff           <= nxt_osc_control;
    end
  end

  // Status: bit 0/1 stable, bit 2/3 still waiting.
  assign osc_status = {28'h0000000,
                       sub_if.osc_enable & ~sub_if.osc_stable,
                       main_if.osc_enable & ~main_if.osc_stable,
                       sub_if.osc_stable,
                       main_if.osc_stable};

  // Reads see the next register values, so a read straight after a write returns the new data.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (HADDR[7:0] == smsc_pkg::SMSC_OFS_STBY) begin
      rd_word = {16'h0000, nxt_standby_control};
    end else if (HADDR[7:0] == smsc_pkg::SMSC_OFS_MAIN_WT) begin
      rd_word = {24'h000000, nxt_main_osc_wait_control};
    end else if (HADDR[7:0] == smsc_pkg::SMSC_OFS_SUB_WT) begin
      rd_word = {24'h000000, nxt_sub_osc_wait_control};
    end else if (HADDR[7:0] == smsc_pkg::SMSC_OFS_STOP_A) begin
      rd_word = nxt_module_stop_control_a;
    end else if (HADDR[7:0] == smsc_pkg::SMSC_OFS_STOP_B) begin
      rd_word = nxt_module_stop_control_b;
    end else if (HADDR[7:0] == smsc_pkg::SMSC_OFS_OSC_CTL) begin
      rd_word = {30'h00000000, nxt_osc_control};
    end else if (HADDR[7:0] == smsc_pkg::SMSC_OFS_OSC_STAT) begin
      rd_word = osc_status;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (bus_take & ~HWRITE) begin
      rdata_ff <= rd_word;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // Oscillator pins: two flip-flops, then an edge detector on the second.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      osc_s1_ff <= 2'h0;
      osc_s2_ff <= 2'h0;
      osc_d_ff  <= 2'h0;
    end else begin
      osc_s1_ff <= {SUB_OSC_IN, MAIN_OSC_IN};
      osc_s2_ff <= osc_s1_ff;
      osc_d_ff  <= osc_s2_ff;
    end
  end

  assign osc_tick = osc_s2_ff & ~osc_d_ff;

  assign main_if.osc_enable = osc_control_ff[0];
  assign main_if.wait_code  = main_osc_wait_control_ff[smsc_pkg::SMSC_WAIT_CODE_W-1:0];
  assign main_if.osc_tick   = osc_tick[0];
  assign sub_if.osc_enable  = osc_control_ff[1];
  assign sub_if.wait_code   = sub_osc_wait_control_ff[smsc_pkg::SMSC_WAIT_CODE_W-1:0];
  assign sub_if.osc_tick    = osc_tick[1];

  smsc_osc_wait u_main_wait (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .wait_if (main_if)
  );

  smsc_osc_wait u_sub_wait (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .wait_if (sub_if)
  );

  // All-module stop is entered when enabled and the core signals standby entry.
  assign all_stop_now = module_stop_control_a_ff[smsc_pkg::SMSC_ALL_MODULE_CLOCK_STOP_ENABLE_BIT] & STANDBY_ENTRY;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      all_stop_ff   <= 1'b0;
      stop_a_out_ff <= smsc_pkg::SMSC_STOP_A_RST;
      stop_b_out_ff <= smsc_pkg::SMSC_STOP_B_RST;
    end else begin
      all_stop_ff   <= all_stop_now;
      stop_a_out_ff <= all_stop_now ? STOP_A_MASK : module_stop_control_a_ff;
      stop_b_out_ff <= all_stop_now ? STOP_B_MASK : module_stop_control_b_ff;
    end
  end

  assign ALL_MODULE_STOP         = all_stop_ff;
  assign MODULE_STOP_A           = stop_a_out_ff;
  assign MODULE_STOP_B           = stop_b_out_ff;
  assign MAIN_OSC_ENABLE         = osc_control_ff[0];
  assign SUB_OSC_ENABLE          = osc_control_ff[1];
  assign MAIN_OSC_STABLE         = main_if.osc_stable;
  assign SUB_OSC_STABLE          = sub_if.osc_stable;
  assign OUTPUT_PORT_ENABLE      = standby_control_ff[smsc_pkg::SMSC_OPE_BIT];
  assign SOFTWARE_STANDBY_SELECT = standby_control_ff[smsc_pkg::SMSC_SOFTWARE_STANDBY_SELECT_BIT];

endmodule // smsc_ctrl

/* shared/smsc_pkg.sv */
// Constants and types shared by the standby wait and module stop controller.
package smsc_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] SMSC_OFS_STBY     = 8'h00;
  localparam logic [7:0] SMSC_OFS_MAIN_WT  = 8'h04;
  localparam logic [7:0] SMSC_OFS_SUB_WT   = 8'h08;
  localparam logic [7:0] SMSC_OFS_STOP_A   = 8'h0c;
  localparam logic [7:0] SMSC_OFS_STOP_B   = 8'h10;
  localparam logic [7:0] SMSC_OFS_OSC_CTL  = 8'h14;
  localparam logic [7:0] SMSC_OFS_OSC_STAT = 8'h18;

  // Standby control field positions.
  localparam int SMSC_OPE_BIT  = 14;
  localparam int SMSC_SOFTWARE_STANDBY_SELECT_BIT = 15;
  localparam logic [15:0] SMSC_STBY_MASK = 16'hc000;

  // Wait code field is five bits starting at bit 0.
  localparam int SMSC_WAIT_CODE_W = 5;
  localparam logic [7:0] SMSC_WAIT_MASK = 8'h1f;

  // Module stop register A groups.
  localparam int SMSC_ALL_MODULE_CLOCK_STOP_ENABLE_BIT = 31;
  localparam logic [31:0] SMSC_A_TIMER   = 32'h0000_0e30;
  localparam logic [31:0] SMSC_A_TPU_CMT = 32'h0000_f000;
  localparam logic [31:0] SMSC_A_CONV    = 32'h308a_0000;
  localparam logic [31:0] SMSC_A_GENERIC = 32'h0900_0000;
  localparam logic [31:0] SMSC_A_ALL_MODULE_CLOCK_STOP_ENABLE    = 32'h8000_0000;

  // Module stop register B groups.
  localparam logic [31:0] SMSC_B_CAN_TEMP = 32'h0000_0117;
  localparam logic [31:0] SMSC_B_COMM     = 32'h00bf_8000;
  localparam logic [31:0] SMSC_B_SCI      = 32'hff00_0000;

  // Values after reset.
  localparam logic [15:0] SMSC_STBY_RST    = 16'h0000;
  localparam logic [7:0]  SMSC_WAIT_RST    = 8'h00;
  localparam logic [31:0] SMSC_STOP_A_RST  = 32'h0000_0000;
  localparam logic [31:0] SMSC_STOP_B_RST  = 32'h0000_0000;
  localparam logic [1:0]  SMSC_OSC_CTL_RST = 2'h0;

  // Oscillator cycles waited for codes 0 to 15.
  localparam int SMSC_WAIT_CNT_W = 20;
  localparam logic [19:0] SMSC_WAIT_TABLE [16] = '{
    20'h00002, 20'h00004, 20'h00008, 20'h00010,
    20'h00020, 20'h00040, 20'h00200, 20'h00400,
    20'h00800, 20'h01000, 20'h04000, 20'h08000,
    20'h10000, 20'h20000, 20'h40000, 20'h80000
  };

  localparam logic [2:0] SMSC_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    SMSC_OFF,
    SMSC_COUNT,
    SMSC_STABLE
  } smsc_wait_state_t;

endpackage

/* shared/smsc_wait_if.sv */
// Signals between the controller and one oscillator wait counter.
`timescale 1ns/1ps
interface smsc_wait_if;
  logic       osc_enable;
  logic [4:0] wait_code;
  logic       osc_tick;
  logic       osc_stable;

  modport ctrl (output osc_enable, output wait_code, output osc_tick, input osc_stable);
  modport counter (input osc_enable, input wait_code, input osc_tick, output osc_stable);
endinterface

/* logic/smsc_osc_wait.sv */
// Oscillator stabilisation wait counter.
`timescale 1ns/1ps
module smsc_osc_wait (
  input wire logic         clk,
  input wire logic         rst,
  smsc_wait_if.counter     wait_if
);

  smsc_pkg::smsc_wait_state_t state_ff;
  smsc_pkg::smsc_wait_state_t nxt_state;
  logic [19:0]                cnt_ff;
  logic [19:0]                nxt_cnt;
  logic [19:0]                target_ff;
  logic [19:0]                nxt_target;
  logic [19:0]                cnt_inc;

  // Codes above the table saturate at the longest wait.
  function automatic logic [19:0] wait_cycles(input logic [4:0] code);
    if (code[4]) begin
      return smsc_pkg::SMSC_WAIT_TABLE[15];
    end
    return smsc_pkg::SMSC_WAIT_TABLE[code[3:0]];
  endfunction

  assign cnt_inc = cnt_ff + 20'h00001;

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_target = target_ff;
    case (state_ff)
      smsc_pkg::SMSC_OFF: begin
        if (wait_if.osc_enable) begin
          nxt_target = wait_cycles(wait_if.wait_code);
          nxt_cnt    = 20'h00000;
          nxt_state  = smsc_pkg::SMSC_COUNT;
        end
      end
      smsc_pkg::SMSC_COUNT: begin
        if (!wait_if.osc_enable) begin
          nxt_state = smsc_pkg::SMSC_OFF;
        end else if (wait_if.osc_tick) begin
          nxt_cnt = cnt_inc;
          if (cnt_inc == target_ff) begin
            nxt_state = smsc_pkg::SMSC_STABLE;
          end
        end
      end
      default: begin
        if (!wait_if.osc_enable) begin
          nxt_state = smsc_pkg::SMSC_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff  <= smsc_pkg::SMSC_OFF;
      cnt_ff    <= 20'h00000;
      target_ff <= 20'h00000;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      target_ff <= nxt_target;
    end
  end

  assign wait_if.osc_stable = (state_ff == smsc_pkg::SMSC_STABLE);

endmodule // smsc_osc_wait

/* tb/smsc_ctrl_asserts.sv */
// Concurrent checks on the ports of the standby wait and module stop controller.
`timescale 1ns/1ps
module smsc_ctrl_asserts (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        STANDBY_ENTRY,
  input wire logic        MAIN_OSC_ENABLE,
  input wire logic        SUB_OSC_ENABLE,
  input wire logic        MAIN_OSC_STABLE,
  input wire logic        SUB_OSC_STABLE,
  input wire logic        OUTPUT_PORT_ENABLE,
  input wire logic        SOFTWARE_STANDBY_SELECT,
  input wire logic        ALL_MODULE_STOP,
  input wire logic [31:0] MODULE_STOP_A,
  input wire logic [31:0] MODULE_STOP_B
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire take;
  wire wr_take;
  assign take    = HSEL && HREADY && HTRANS[1];
  assign wr_take = take && HWRITE && HSIZE == 3'h2;
  property p_stop_a;
    logic [31:0] d;
    (wr_take && HADDR[7:0] == 8'h0c) ##1 (1'b1, d = HWDATA)
      |-> ##2 (ALL_MODULE_STOP || MODULE_STOP_A == (d & 32'hb98afe30));
  endproperty
  property p_stop_b;
    logic [31:0] d;
    (wr_take && HADDR[7:0] == 8'h10) ##1 (1'b1, d = HWDATA)
      |-> ##2 (ALL_MODULE_STOP || MODULE_STOP_B == (d & 32'hffbf8117));
  endproperty
  property p_stby;
    logic [31:0] d;
    (wr_take && HADDR[7:0] == 8'h00) ##1 (1'b1, d = HWDATA)
      |-> ##1 (OUTPUT_PORT_ENABLE == d[14] && SOFTWARE_STANDBY_SELECT == d[15]);
  endproperty
  a_stop_a_write: assert property (p_stop_a)
    else $error("stop output A differs from written value");
  a_stop_b_write: assert property (p_stop_b)
    else $error("stop output B differs from written value");
  a_stby_write: assert property (p_stby)
    else $error("standby bits differ from written value");
  a_all_force: assert property (ALL_MODULE_STOP [*2] |->
    (&(MODULE_STOP_A | ~32'hb98afe30)) && (&(MODULE_STOP_B | ~32'hffbf8117)))
    else $error("all-module stop left a clock running");
  a_all_cause: assert property (ALL_MODULE_STOP |-> $past(STANDBY_ENTRY))
    else $error("all-module stop without standby");
  a_main_needs_en: assert property (MAIN_OSC_STABLE |-> $past(MAIN_OSC_ENABLE))
    else $error("main stable while disabled");
  a_sub_wait_hold: assert property ($rose(SUB_OSC_ENABLE) |-> !SUB_OSC_STABLE [*4])
    else $error("sub stable too early");
  a_rdata_idle: assert property (!$past(take && !HWRITE) |-> HRDATA == 32'h0)
    else $error("read data outside data phase");
  c_all_stop: cover property (ALL_MODULE_STOP);
  c_main_stable: cover property ($rose(MAIN_OSC_STABLE));
  c_sub_stable: cover property ($rose(SUB_OSC_STABLE));
endmodule // smsc_ctrl_asserts

bind smsc_ctrl smsc_ctrl_asserts u_chk (.*);

/* tb/smsc_ctrl_test.sv */
// Self-checking bench of the standby wait and module stop controller.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) begin \
      err_count++; \
      $display("unexpected at %0t: %h not %h", $time, (a), (b)); \
    end \
  end
module smsc_ctrl_test;
  logic        CLOCK, SYS_RST, HSEL, HWRITE, HREADY, MAIN_OSC_IN, SUB_OSC_IN, STANDBY_ENTRY;
  logic [31:0] HADDR, HWDATA, HRDATA, MODULE_STOP_A, MODULE_STOP_B, rd;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic        HREADYOUT, HRESP, MAIN_OSC_ENABLE, SUB_OSC_ENABLE, MAIN_OSC_STABLE, SUB_OSC_STABLE;
  logic        OUTPUT_PORT_ENABLE, SOFTWARE_STANDBY_SELECT, ALL_MODULE_STOP;
  int          err_count, checks, seed;
  logic [31:0] shadow [6];
  localparam logic [31:0] mask_tbl [6] = '{32'hc000, 32'h1f, 32'h1f, 32'hb98afe30, 32'hffbf8117, 32'h3};
  localparam int wait_tbl [7] = '{2, 4, 8, 16, 32, 64, 512};
  assign HREADY = HREADYOUT;
  smsc_ctrl u_dut (.*);
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  function automatic logic [31:0] reg_val(int i, logic [31:0] d);
    return d & mask_tbl[i];
  endfunction
  task automatic test_done;
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 16);
    if (HREADYOUT !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: bus hang", $time);
      test_done();
    end
  endtask
  // Every read also checks that the slave answered OKAY.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic [2:0] sz);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    HSIZE <= sz;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    rd = HRDATA;
    `CHK(HRESP, 1'b0)
    if (wr && sz == 3'h2 && a < 8'h18) shadow[a[4:2]] = reg_val(int'(a[4:2]), d);
  endtask
  task automatic chk_out;
    repeat (2) @(posedge CLOCK);
    `CHK(OUTPUT_PORT_ENABLE, shadow[0][14])
    `CHK(SOFTWARE_STANDBY_SELECT, shadow[0][15])
    `CHK(MODULE_STOP_A, shadow[3])
    `CHK(MODULE_STOP_B, shadow[4])
    `CHK({SUB_OSC_ENABLE, MAIN_OSC_ENABLE}, shadow[5][1:0])
  endtask
  task automatic chk_zero;
    for (int i = 0; i < 9; i++) begin
      bus(8'(4 * i), 1'b0, 32'h0, 3'h2);
      `CHK(rd, 32'h0)
    end
    chk_out();
  endtask
  task automatic osc_pulse(input bit sub, input int n);
    repeat (n) begin
      if (sub) SUB_OSC_IN <= 1'b1;
      else MAIN_OSC_IN <= 1'b1;
      repeat (3) @(posedge CLOCK);
      SUB_OSC_IN <= 1'b0;
      MAIN_OSC_IN <= 1'b0;
      repeat (3) @(posedge CLOCK);
    end
  endtask
  initial begin
    logic [31:0] d;
    bit          sub;
    int          code;
    seed = 32'h5774;
    {HSEL, HWRITE, HADDR, HWDATA, HTRANS, HSIZE} = '0;
    {MAIN_OSC_IN, SUB_OSC_IN, STANDBY_ENTRY} = '0;
    SYS_RST = 1'b1;
    shadow = '{default: 32'h0};
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    chk_zero();
    for (int k = 0; k < 36; k++) begin
      d = (k < 6) ? 32'hffffffff : $random(seed);
      bus(8'(4 * (k % 6)), 1'b1, d, 3'h2);
      chk_out();
      bus(8'(4 * (k % 6)), 1'b0, 32'h0, 3'h2);
      `CHK(rd, shadow[k % 6])
    end
    // Byte writes, unmapped and read-only places must leave the standby, stop and oscillator enable outputs alone.
    bus(8'h0c, 1'b1, ~shadow[3], 3'h0);
    bus(8'h1c, 1'b1, 32'hffffffff, 3'h2);
    bus(8'h18, 1'b1, 32'hffffffff, 3'h2);
    chk_out();
    bus(8'h1c, 1'b0, 32'h0, 3'h2);
    `CHK(rd, 32'h0)
    for (int j = 0; j < 9; j++) begin
      sub = j > 6;
      code = sub ? (j - 7) * 3 : j;
      bus(8'h14, 1'b1, 32'h0, 3'h2);
      bus(sub ? 8'h08 : 8'h04, 1'b1, 32'(code), 3'h2);
      `CHK({SUB_OSC_STABLE, MAIN_OSC_STABLE}, 2'h0)
      bus(8'h14, 1'b1, sub ? 32'h2 : 32'h1, 3'h2);
      repeat (2) @(posedge CLOCK);
      osc_pulse(sub, wait_tbl[code] - 1);
      repeat (8) @(posedge CLOCK);
      `CHK(sub ? SUB_OSC_STABLE : MAIN_OSC_STABLE, 1'b0)
      bus(8'h18, 1'b0, 32'h0, 3'h2);
      `CHK(rd, sub ? 32'h8 : 32'h4)
      osc_pulse(sub, 1);
      repeat (4) @(posedge CLOCK);
      `CHK(sub ? SUB_OSC_STABLE : MAIN_OSC_STABLE, 1'b1)
      bus(8'h18, 1'b0, 32'h0, 3'h2);
      `CHK(rd, sub ? 32'h2 : 32'h1)
    end
    bus(8'h0c, 1'b1, 32'h0, 3'h2);
    STANDBY_ENTRY <= 1'b1;
    repeat (4) @(posedge CLOCK);
    `CHK(ALL_MODULE_STOP, 1'b0)
    STANDBY_ENTRY <= 1'b0;
    bus(8'h0c, 1'b1, 32'h80000000, 3'h2);
    STANDBY_ENTRY <= 1'b1;
    repeat (4) @(posedge CLOCK);
    `CHK(ALL_MODULE_STOP, 1'b1)
    `CHK(MODULE_STOP_A, mask_tbl[3])
    `CHK(MODULE_STOP_B, mask_tbl[4])
    bus(8'h0c, 1'b0, 32'h0, 3'h2);
    `CHK(rd, 32'h80000000)
    STANDBY_ENTRY <= 1'b0;
    repeat (4) @(posedge CLOCK);
    `CHK(ALL_MODULE_STOP, 1'b0)
    chk_out();
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    shadow = '{default: 32'h0};
    chk_zero();
    test_done();
  end
endmodule // smsc_ctrl_test
